// file: logic/hpc_pkg.sv
// package for the hardware pin configuration block
// assumes a 32-bit ahb-lite register bus and a 200 MHz clock
`default_nettype none

package hpc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [31:0] PIN_SETUP_ADDR  = 32'h0000_00a4; // hardware_pin_setup
    localparam logic [31:0] PIN_STATUS_ADDR = 32'h0000_00b0; // read-only state view
    localparam logic [31:0] PIN_SETUP_RST   = 32'h0000_0000;
    localparam logic [31:0] PIN_SETUP_MASK  = 32'h0800_07ff; // implemented bits

    // ****************************************
    // field positions of hardware_pin_setup
    // ****************************************
    localparam int FILT_BYP_BIT   = 27;
    localparam int FB_STOP_LSB    = 9;
    localparam int FB_FAULT_LSB   = 7;
    localparam int ALARM_EN_BIT   = 6;
    localparam int BRAKE_MODE_BIT = 5;
    localparam int ANGLE_SEL_BIT  = 4;
    localparam int BRAKE_OVR_LSB  = 2;
    localparam int SPEED_SRC_LSB  = 0;

    // ****************************************
    // field positions of the status register
    // ****************************************
    localparam int ST_FB_BIT     = 0;
    localparam int ST_LOWSIDE_BIT = 1;
    localparam int ST_ALIGN_BIT  = 2;
    localparam int ST_LAST_BIT   = 3;

    // ****************************************
    // field encodings
    // ****************************************
    localparam logic [1:0] FB_STOP_GENERAL  = 2'h0;
    localparam logic [1:0] FB_STOP_HIGH     = 2'h1;
    localparam logic [1:0] FB_STOP_LOW      = 2'h2;
    localparam logic [1:0] FB_STOP_HIGH2    = 2'h3;
    localparam logic [1:0] FB_FAULT_HOLD    = 2'h0;
    localparam logic [1:0] FB_FAULT_HIGH    = 2'h1;
    localparam logic [1:0] FB_FAULT_LOW     = 2'h2;
    localparam logic [1:0] FB_FAULT_GENERAL = 2'h3;
    localparam logic [1:0] BRK_PIN          = 2'h0;
    localparam logic [1:0] BRK_FORCE        = 2'h1;
    localparam logic [1:0] BRK_NEVER        = 2'h2;
    localparam logic [1:0] BRK_PIN2         = 2'h3;

    // ****************************************
    // ahb-lite codes
    // ****************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage

`default_nettype wire

// file: logic/hpc_cfg_if.sv
// interface between the register bank and the pin control logic
// assumes both ends share one clock
`default_nettype none

interface hpc_cfg_if;
    // configuration fields
    logic [1:0] fb_stop;
    logic [1:0] fb_fault;
    logic       brake_align;
    logic [1:0] brake_ovr;
    // state back to the register bank
    logic       fb_level;
    logic       brake_lowside;
    logic       brake_alignact;
    logic       fb_last;

    modport regs (
        output fb_stop, fb_fault, brake_align, brake_ovr,
        input  fb_level, brake_lowside, brake_alignact, fb_last
    );
    modport pins (
        input  fb_stop, fb_fault, brake_align, brake_ovr,
        output fb_level, brake_lowside, brake_alignact, fb_last
    );
endinterface

`default_nettype wire

// file: logic/hpc_pin_ctl.sv
// speed feedback and brake output logic
// assumes configuration from the register bank via hpc_cfg_if
`default_nettype none

module hpc_pin_ctl (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // motor state
    input  wire logic motor_stopped,
    input  wire logic fault_active,
    input  wire logic fb_drive,
    input  wire logic fb_general,
    input  wire logic brake_pin,
    // configuration
    hpc_cfg_if.pins   cfg
);

    logic fb_r, fb_nxt;
    logic last_r, last_nxt;
    logic low_r, low_nxt;
    logic aln_r, aln_nxt;
    logic brake_req;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        last_nxt = last_r;
        if (!motor_stopped && !fault_active) begin
            last_nxt = fb_drive;
        end
        fb_nxt = fb_drive;
        if (fault_active) begin
            // RL4 fault feedback select
            case (cfg.fb_fault)
                hpc_pkg::FB_FAULT_HOLD:    fb_nxt = last_r;
                hpc_pkg::FB_FAULT_HIGH:    fb_nxt = 1'b1;
                hpc_pkg::FB_FAULT_LOW:     fb_nxt = 1'b0;
                hpc_pkg::FB_FAULT_GENERAL: fb_nxt = fb_general;
                default:                   fb_nxt = last_r;
            endcase
        end else if (motor_stopped) begin
            // RL3 stopped feedback select
            case (cfg.fb_stop)
                hpc_pkg::FB_STOP_GENERAL: fb_nxt = fb_general;
                hpc_pkg::FB_STOP_HIGH:    fb_nxt = 1'b1;
                hpc_pkg::FB_STOP_LOW:     fb_nxt = 1'b0;
                hpc_pkg::FB_STOP_HIGH2:   fb_nxt = 1'b1;
                default:                  fb_nxt = fb_general;
            endcase
        end
        // RL8 brake input override
        case (cfg.brake_ovr)
            hpc_pkg::BRK_PIN:   brake_req = brake_pin;
            hpc_pkg::BRK_FORCE: brake_req = 1'b1;
            hpc_pkg::BRK_NEVER: brake_req = 1'b0;
            hpc_pkg::BRK_PIN2:  brake_req = brake_pin;
            default:            brake_req = brake_pin;
        endcase
        // RL6 low side or align
        low_nxt = brake_req & ~cfg.brake_align;
        aln_nxt = brake_req & cfg.brake_align;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_r   <= 1'b0;
            last_r <= 1'b0;
            low_r  <= 1'b0;
            aln_r  <= 1'b0;
        end else begin
            fb_r   <= fb_nxt;
            last_r <= last_nxt;
            low_r  <= low_nxt;
            aln_r  <= aln_nxt;
        end
    end

    // outputs back to the bank
    assign cfg.fb_level       = fb_r;
    assign cfg.brake_lowside  = low_r;
    assign cfg.brake_alignact = aln_r;
    assign cfg.fb_last        = last_r;

endmodule

`default_nettype wire

// file: logic/hpc_top.sv
// hardware pin configuration register with ahb-lite slave and pin control
// assumes a single-master ahb-lite bus, zero wait states, one clock
//
// How it works
// RL1 - one 32-bit read/write register at a4h that clears to all zeros on reset.
// RL2 - bit 27 set bypasses the bus voltage filter, clear keeps it active.
// RL3 - while stopped, bits 10-9 give feedback: 0 general setting, 1 and 3 high, 2 low.
// RL4 - in a fault, bits 8-7 give feedback: 0 last driven level, 1 high, 2 low, 3 general.
// RL5 - bit 6 set enables the alarm pin function, clear leaves it disabled.
// RL6 - bit 5 clear brakes with all low-side switches, set brakes by align.
// RL7 - bit 4 clear aligns at the last commutation angle, set at the configured angle.
// RL8 - bits 3-2: 0 and 3 follow the brake pin, 1 forces brake, 2 never brakes.
// RL9 - bits 1-0 pick the speed command: analog, duty, serial value or frequency.
// RL10 - software writes zeros to reserved bits and does not rely on them.
//
// The AHB-Lite slave port was chosen for this implementation.
`default_nettype none

module hpc_top (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // motor state
    input  wire logic        MOTOR_STOPPED,
    input  wire logic        FAULT_ACTIVE,
    input  wire logic        FB_DRIVE,
    input  wire logic        FEEDBACK_OUT_GENERAL_SETTING,
    input  wire logic        BRAKE_PIN,
    // configuration outputs
    output logic             BUS_VOLTAGE_FILTER_BYPASS,
    output logic             ALARM_PIN_ENABLE,
    output logic             ALIGN_ANGLE_CONFIGURED,
    output logic      [1:0]  SPEED_SOURCE,
    // pin control outputs
    output logic             SPEED_FEEDBACK_OUTPUT,
    output logic             BRAKE_LOW_SIDE,
    output logic             BRAKE_ALIGN
);

    hpc_cfg_if cfg ();

    logic [31:0] setup_r, setup_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [31:0] waddr_r, waddr_nxt;
    logic        addr_phase;
    logic [31:0] status_w;

    // ****************************************
    // bus decode
    // ****************************************
    // valid transfer in its address phase
    assign addr_phase = HSEL && HREADY && (HTRANS == hpc_pkg::HTRANS_NONSEQ);

    // block state for the status view
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[hpc_pkg::ST_FB_BIT]      = cfg.fb_level;
        status_w[hpc_pkg::ST_LOWSIDE_BIT] = cfg.brake_lowside;
        status_w[hpc_pkg::ST_ALIGN_BIT]   = cfg.brake_alignact;
        status_w[hpc_pkg::ST_LAST_BIT]    = cfg.fb_last;
    end

    // ****************************************
    // register next values
    // ****************************************
    always_comb begin
        setup_nxt   = setup_r;
        wr_pend_nxt = 1'b0;
        waddr_nxt   = waddr_r;
        rdata_nxt   = rdata_r;
        // RL1 data phase write
        if (wr_pend_r && (waddr_r == hpc_pkg::PIN_SETUP_ADDR)) begin
            // RL10 reserved bits kept zero
            setup_nxt = HWDATA & hpc_pkg::PIN_SETUP_MASK;
        end
        if (addr_phase) begin
            wr_pend_nxt = HWRITE;
            waddr_nxt   = HADDR;
            if (!HWRITE) begin
                // RL1 read back, newest value
                if (HADDR == hpc_pkg::PIN_SETUP_ADDR) begin
                    rdata_nxt = setup_nxt;
                end else if (HADDR == hpc_pkg::PIN_STATUS_ADDR) begin
                    rdata_nxt = status_w;
                end else begin
                    rdata_nxt = 32'h0000_0000;
                end
            end
        end
    end

    // RL1 reset to zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            setup_r   <= hpc_pkg::PIN_SETUP_RST;
            rdata_r   <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            waddr_r   <= 32'h0000_0000;
        end else begin
            setup_r   <= setup_nxt;
            rdata_r   <= rdata_nxt;
            wr_pend_r <= wr_pend_nxt;
            waddr_r   <= waddr_nxt;
        end
    end

    // ****************************************
    // bus response
    // ****************************************
    assign HRDATA    = rdata_r;
    assign HREADYOUT = 1'b1;                 // zero wait states
    assign HRESP     = hpc_pkg::HRESP_OKAY;

    // ****************************************
    // field fan-out
    // ****************************************
    // RL2 filter bypass
    assign BUS_VOLTAGE_FILTER_BYPASS = setup_r[hpc_pkg::FILT_BYP_BIT];
    // RL5 alarm enable
    assign ALARM_PIN_ENABLE          = setup_r[hpc_pkg::ALARM_EN_BIT];
    // RL7 align angle source
    assign ALIGN_ANGLE_CONFIGURED    = setup_r[hpc_pkg::ANGLE_SEL_BIT];
    // RL9 speed command source
    assign SPEED_SOURCE = setup_r[hpc_pkg::SPEED_SRC_LSB +: 2];

    assign cfg.fb_stop     = setup_r[hpc_pkg::FB_STOP_LSB +: 2];
    assign cfg.fb_fault    = setup_r[hpc_pkg::FB_FAULT_LSB +: 2];
    assign cfg.brake_align = setup_r[hpc_pkg::BRAKE_MODE_BIT];
    assign cfg.brake_ovr   = setup_r[hpc_pkg::BRAKE_OVR_LSB +: 2];

    // ****************************************
    // pin control
    // ****************************************
    hpc_pin_ctl u_pin_ctl (
        .clk           (CLK),
        .rst_n         (RST_N),
        .motor_stopped (MOTOR_STOPPED),
        .fault_active  (FAULT_ACTIVE),
        .fb_drive      (FB_DRIVE),
        .fb_general    (FEEDBACK_OUT_GENERAL_SETTING),
        .brake_pin     (BRAKE_PIN),
        .cfg           (cfg.pins)
    );

    assign SPEED_FEEDBACK_OUTPUT = cfg.fb_level;
    assign BRAKE_LOW_SIDE        = cfg.brake_lowside;
    assign BRAKE_ALIGN           = cfg.brake_alignact;

endmodule

`default_nettype wire

// file: bench/hpc_top_sva.sv
// assertion checker for hpc_top, bound at the foot of this file
// assumes zero-wait bus timing and one-cycle pin control latency
`default_nettype none
module hpc_chk (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // bus
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // motor state
    input wire logic        MOTOR_STOPPED,
    input wire logic        FAULT_ACTIVE,
    input wire logic        FB_DRIVE,
    input wire logic        FEEDBACK_OUT_GENERAL_SETTING,
    input wire logic        BRAKE_PIN,
    // outputs
    input wire logic        BUS_VOLTAGE_FILTER_BYPASS,
    input wire logic        ALARM_PIN_ENABLE,
    input wire logic        ALIGN_ANGLE_CONFIGURED,
    input wire logic [1:0]  SPEED_SOURCE,
    input wire logic        SPEED_FEEDBACK_OUTPUT,
    input wire logic        BRAKE_LOW_SIDE,
    input wire logic        BRAKE_ALIGN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        take, wr_ph_r, wr_ph_nxt, rd_ph_r, rd_ph_nxt, wr_d_r, quiet, fb_exp, brk;
    logic [4:0]  pins_in, prev_in_r;
    logic [1:0]  brk_exp;
    logic [31:0] shadow_r, shadow_nxt;
    // ****************************
    // register shadow, expected pins
    // ****************************
    always_comb begin
        take = HSEL && HREADY && HTRANS == hpc_pkg::HTRANS_NONSEQ
               && HADDR == hpc_pkg::PIN_SETUP_ADDR;
        wr_ph_nxt = take && HWRITE;
        rd_ph_nxt = take && !HWRITE;
        shadow_nxt = wr_ph_r ? (HWDATA & hpc_pkg::PIN_SETUP_MASK) : shadow_r;
        pins_in = {MOTOR_STOPPED, FAULT_ACTIVE, FB_DRIVE, FEEDBACK_OUT_GENERAL_SETTING,
                   BRAKE_PIN};
        if (FAULT_ACTIVE)
            fb_exp = shadow_r[8:7] == 2'h3 ? pins_in[1] : shadow_r[8:7] == 2'h1;
        else if (MOTOR_STOPPED)
            fb_exp = shadow_r[10:9] == 2'h0 ? pins_in[1] : shadow_r[10:9] != 2'h2;
        else
            fb_exp = FB_DRIVE;
        brk = shadow_r[3:2] == 2'h1 || (shadow_r[3:2] != 2'h2 && BRAKE_PIN);
        brk_exp = {brk && !shadow_r[5], brk && shadow_r[5]};
        // hold-last code excluded: its latch point is a design choice
        quiet = !wr_ph_r && !wr_d_r && pins_in == prev_in_r
                && !(FAULT_ACTIVE && shadow_r[8:7] == 2'h0);
    end
    // helper registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            {wr_ph_r, rd_ph_r, wr_d_r, prev_in_r, shadow_r} <= '0;
        end else begin
            {wr_ph_r, rd_ph_r, wr_d_r} <= {wr_ph_nxt, rd_ph_nxt, wr_ph_r};
            prev_in_r <= pins_in;
            shadow_r <= shadow_nxt;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_wr_done;
        wr_ph_r ##1 !wr_ph_r;
    endsequence
    a_bus_okay: assert property (HREADYOUT && HRESP == hpc_pkg::HRESP_OKAY)
        else $error("bus stalled or errored");
    a_read_back: assert property (rd_ph_r |-> HRDATA == shadow_r)
        else $error("read data wrong");
    a_filter_bypass: assert property (s_wr_done |=>
        BUS_VOLTAGE_FILTER_BYPASS == shadow_r[27])
        else $error("filter bypass wrong");
    a_alarm_enable: assert property (s_wr_done |=> ALARM_PIN_ENABLE == shadow_r[6])
        else $error("alarm enable wrong");
    a_angle_select: assert property (s_wr_done |=> ALIGN_ANGLE_CONFIGURED == shadow_r[4])
        else $error("angle select wrong");
    a_speed_source: assert property (s_wr_done |=> SPEED_SOURCE == shadow_r[1:0])
        else $error("speed source wrong");
    a_feedback_level: assert property (quiet [*2] |=>
        SPEED_FEEDBACK_OUTPUT == $past(fb_exp))
        else $error("feedback level wrong");
    a_brake_outputs: assert property (quiet [*2] |=>
        {BRAKE_LOW_SIDE, BRAKE_ALIGN} == $past(brk_exp))
        else $error("brake outputs wrong");
endmodule
bind hpc_top hpc_chk chk (.*);
`default_nettype wire

// file: bench/hpc_tb.sv
// self-checking bench for hpc_top
// assumes package and design files are compiled first
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b1, HWRITE = 1'b0, HREADY;
    logic        MOTOR_STOPPED = 1'b0, FAULT_ACTIVE = 1'b0, FB_DRIVE = 1'b0, BRAKE_PIN = 1'b0;
    logic        FEEDBACK_OUT_GENERAL_SETTING = 1'b0, HREADYOUT, HRESP, SPEED_FEEDBACK_OUTPUT;
    logic        BUS_VOLTAGE_FILTER_BYPASS, ALARM_PIN_ENABLE, ALIGN_ANGLE_CONFIGURED;
    logic        BRAKE_LOW_SIDE, BRAKE_ALIGN;
    logic [1:0]  HTRANS = 2'h0, SPEED_SOURCE;
    logic [2:0]  HSIZE = 3'h2;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
    logic [4:0]  cfg;
    int          err_count = 0, checks_done = 0;
    localparam logic [31:0] A = hpc_pkg::PIN_SETUP_ADDR;
    hpc_top dut (.*);
    assign HREADY = HREADYOUT;
    assign cfg = {BUS_VOLTAGE_FILTER_BYPASS, ALARM_PIN_ENABLE, ALIGN_ANGLE_CONFIGURED,
                  SPEED_SOURCE};
    always #2.5 CLK = ~CLK;
    // ****************************
    // bus and pin tasks
    // ****************************
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // wait for ready, data taken at the falling edge before the rising edge that ends the wait
    task automatic wait_rdy(output logic [31:0] q);
        logic r;
        for (int n = 0; n < 50; n++) begin
            @(negedge CLK);
            q = HRDATA;
            r = HREADY;
            @(posedge CLK);
            if (r === 1'b1)
                return;
        end
        err_count++;
        give_verdict();
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge CLK);
        HTRANS <= hpc_pkg::HTRANS_NONSEQ;
        HWRITE <= w;
        HADDR <= a;
        wait_rdy(q);
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy(q);
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [31:0] a, e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask
    // drive stopped, fault, drive level, general level, brake pin
    task automatic pins(input logic [4:0] v);
        @(posedge CLK);
        {MOTOR_STOPPED, FAULT_ACTIVE, FB_DRIVE, FEEDBACK_OUT_GENERAL_SETTING, BRAKE_PIN} <= v;
        repeat (4) @(posedge CLK);
        @(negedge CLK);
    endtask
    // ****************************
    // scenarios
    // ****************************
    task automatic t_regs;
        logic [31:0] d;
        rd_chk(A, 32'h0);
        wr(A, 32'h0800_07ff);
        rd_chk(A, 32'h0800_07ff);
        for (int i = 0; i < 4; i++) begin
            d = {4'h0, i[0], 20'h0, i[1], 1'b0, i[0], 2'h0, i[1:0]};
            wr(A, d);
            rd_chk(A, d);
            pins(5'h0);
            `CHK(cfg, {i[0], i[1], i[0], i[1:0]})
        end
        wr(32'h0000_0100, 32'hffff_ffff);
        rd_chk(32'h0000_0100, 32'h0);
        rd_chk(A, 32'h0800_0053);
    endtask
    // mid-run reset clears the register and the bus data
    task automatic t_reset;
        wr(A, 32'h0800_0053);
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        @(negedge CLK);
        `CHK(cfg, 5'h00)
        `CHK(HRDATA, 32'h0)
        rd_chk(A, 32'h0);
    endtask
    task automatic t_stop;
        logic e;
        for (int c = 0; c < 4; c++) begin
            for (int g = 0; g < 2; g++) begin
                e = c == 0 ? g[0] : c != 2;
                wr(A, {21'h0, c[1:0], 9'h0});
                pins({1'b1, 1'b0, !e, g[0], 1'b0});
                `CHK(SPEED_FEEDBACK_OUTPUT, e)
            end
        end
    endtask
    task automatic t_fault;
        logic e;
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 2; d++) begin
                e = c == 0 ? d[0] : c == 3 ? !d[0] : c == 1;
                wr(A, {23'h0, c[1:0], 7'h0});
                pins({2'h0, d[0], 2'h0});
                pins({2'h3, !d[0], !d[0], 1'b0});
                `CHK(SPEED_FEEDBACK_OUTPUT, e)
            end
        end
    endtask
    task automatic t_brake;
        logic q;
        for (int m = 0; m < 2; m++) begin
            for (int o = 0; o < 4; o++) begin
                for (int p = 0; p < 2; p++) begin
                    q = o == 1 || (o != 2 && p == 1);
                    wr(A, {26'h0, m[0], 1'b0, o[1:0], 2'h0});
                    pins({4'h0, p[0]});
                    `CHK({BRAKE_LOW_SIDE, BRAKE_ALIGN}, {q && !m[0], q && m[0]})
                    rd_chk(hpc_pkg::PIN_STATUS_ADDR, {29'h0, q && m[0], q && !m[0], 1'b0});
                end
            end
        end
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        t_regs();
        t_reset();
        t_stop();
        t_fault();
        t_brake();
        give_verdict();
    end
endmodule
`default_nettype wire
